// ==== rtl/line_test_loop_control.sv ====
// Test pattern, loopback and transmit clock control of a line unit
// How it works
// - Pattern setting sends continuous 511-bit sequence
// - Checker pulses error output per mismatch
// - Variant corrupts bits at a steady rate
// - Pattern runs alone or with local loopback, never during network loop
// - Sealing reversal loops line, lights test mode
// - Loop command code loops data, lights indicator
// - Transmit clock source chosen per loop state
// - Local loop request routes transmit to receiver
// - Remote loop request commands far-end loop
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "line_test_defines.svh"
module line_test_loop_control #(
  parameter int INT_DIV = `LT_INT_BIT_NS / `LT_CLK_PERIOD_NS,
  parameter int SEND_BITS = `LT_CMD_SEND_BITS,
  parameter int DETECT_BITS = `LT_CMD_DETECT_BITS,
  parameter logic [7:0] LOOP_CODE = `LT_LOOP_CODE,
  parameter logic [7:0] EXIT_CODE = `LT_EXIT_CODE
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic LINE_RX_DATA_IN,
  input wire logic RECOVERED_RECEIVE_CLOCK_IN,
  input wire logic TERMINAL_SUPPLIED_TX_CLOCK_IN,
  input wire logic TERM_TX_DATA_IN,
  input wire logic LOCAL_LOOP_REQUEST_IN,
  input wire logic REMOTE_LOOP_REQUEST_IN,
  input wire logic SEALING_REVERSED_IN,
  output logic LINE_TX_DATA_OUT,
  output logic UNIT_SUPPLIED_TX_CLOCK_OUT,
  output logic TERM_RX_DATA_OUT,
  output logic TEST_MODE_INDICATOR_OUT,
  output logic ERROR_PULSE_OUT,
  output logic IRQ_OUT
);
  // Same decision is made twice, once for each code
  function automatic logic code_seen(input logic [7:0] win, input logic [7:0] run,
                                     input logic [7:0] code);
    code_seen = (run >= 8'(DETECT_BITS)) && (win == code);
  endfunction

  // Transmit clock source per mode and loop state
  function automatic line_test_pkg::clk_src_t pick_src(input logic [1:0] mode,
                                                       input logic analog, input logic net);
    if (analog) pick_src = line_test_pkg::SRC_INT;
    else if (mode == line_test_pkg::CLK_MODE_EXT) pick_src = line_test_pkg::SRC_EXT;
    else if (mode == line_test_pkg::CLK_MODE_NET || net) pick_src = line_test_pkg::SRC_RC;
    else pick_src = line_test_pkg::SRC_INT;
  endfunction

  // Pin synchronisers: bit 0 rx data, 1 rx clock, 2 ext clock, 3 user data,
  // 4 local loop, 5 remote loop, 6 sealing reversal
  logic [6:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic rc_edge, ext_edge;             // Rising edges of the two pin clocks
  logic analog, net_loop;              // Local analog loop, any network loop
  logic [11:0] div_q, div_d;           // Internal bit-rate divider
  logic int_tick;                      // Internal bit-rate enable
  line_test_pkg::clk_src_t src;        // Chosen transmit timing
  logic tx_en, rx_en, rx_bit;          // Bit strobes and received bit
  logic pat_on, gen_bit, chk_err, chk_sync;
  logic tx_bit_q, tx_bit_d, tx_clk_q, tx_clk_d, tx_en_q;
  logic rx_last_q, rx_last_d;          // Last received bit
  logic [7:0] win_q, win_d, run_q, run_d; // Command window and repeat run
  logic cmd_loop_q, cmd_loop_d;        // Loop entered by command code
  line_test_pkg::rl_state_t rl_q, rl_d;
  logic [7:0] send_q, send_d;          // Command bits sent
  logic tm_q, tm_d, err_q, net_q;
  logic [3:0] ctrl_q, ctrl_d;          // Clock mode and pattern mode
  logic [2:0] stat_q, stat_d, mask_q, mask_d, ev;
  logic [15:0] errcnt_q, errcnt_d;
  logic ack_d, req, wr, irq_d;
  logic [31:0] rdat_d;

  // Two flops per pin, third stage only for edge detection
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
      pin_s3_q <= 7'h00;
    end else begin
      pin_s1_q <= {SEALING_REVERSED_IN, REMOTE_LOOP_REQUEST_IN, LOCAL_LOOP_REQUEST_IN,
                   TERM_TX_DATA_IN, TERMINAL_SUPPLIED_TX_CLOCK_IN,
                   RECOVERED_RECEIVE_CLOCK_IN, LINE_RX_DATA_IN};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign rc_edge = pin_s2_q[1] & ~pin_s3_q[1];
  assign ext_edge = pin_s2_q[2] & ~pin_s3_q[2];
  assign analog = pin_s2_q[4];
  assign net_loop = pin_s2_q[6] | cmd_loop_q;
  assign int_tick = (div_q == 12'h000);
  assign src = pick_src(ctrl_q[1:0], analog, net_loop);
  // Pattern mode; with the local loop active one unit checks its own pattern
  assign pat_on = (ctrl_q[3:2] == line_test_pkg::PAT_511) ||
                  (ctrl_q[3:2] == line_test_pkg::PAT_511E);
  // In analog loop the receiver reads our own transmit bit a cycle later
  assign rx_en = analog ? tx_en_q : rc_edge;
  assign rx_bit = analog ? tx_bit_q : pin_s2_q[0];

  // Transmit strobe from the chosen timing source
  always_comb begin
    unique case (src)
      line_test_pkg::SRC_EXT: tx_en = ext_edge;
      line_test_pkg::SRC_RC: tx_en = rc_edge;
      default: tx_en = int_tick;
    endcase
  end

  prbs9_gen #(.INTERVAL(`LT_PRBS_INTERVAL)) u_gen (
    .clk_in(CLK_SYS_IN),
    .rst_in(RESET_IN),
    .step_in(tx_en && pat_on && !net_loop),
    .inject_in(ctrl_q[3:2] == line_test_pkg::PAT_511E),
    .bit_out(gen_bit)
  );

  // Checker sees loopback or line bits; far end must run its pattern too
  prbs9_chk u_chk (
    .clk_in(CLK_SYS_IN),
    .rst_in(RESET_IN),
    .step_in(rx_en && pat_on && !net_loop),
    .bit_in(rx_bit),
    .clear_in(!pat_on),
    .err_out(chk_err),
    .synced_out(chk_sync)
  );

  // Line datapath, loop states and command handling
  always_comb begin
    div_d = int_tick ? 12'(INT_DIV - 1) : div_q - 12'h001;
    tx_bit_d = tx_bit_q;
    tx_clk_d = tx_en;
    rx_last_d = rx_en ? rx_bit : rx_last_q;
    win_d = win_q;
    run_d = run_q;
    cmd_loop_d = cmd_loop_q;
    rl_d = rl_q;
    send_d = send_q;
    if (rx_en && !analog) begin
      win_d = {win_q[6:0], rx_bit};
      // Run of bits repeating with period eight, saturating
      run_d = (rx_bit == win_q[7]) ? ((run_q == 8'hFF) ? run_q : run_q + 8'h01) : 8'h00;
      if (!cmd_loop_q && code_seen(win_q, run_q, LOOP_CODE)) cmd_loop_d = 1'b1;
      else if (cmd_loop_q && code_seen(win_q, run_q, EXIT_CODE)) cmd_loop_d = 1'b0;
    end
    if (tx_en) begin
      if (net_loop) begin
        tx_bit_d = rx_last_q;
      end else if (rl_q == line_test_pkg::RL_ARM) begin
        tx_bit_d = LOOP_CODE[3'h7 - send_q[2:0]];
      end else if (rl_q == line_test_pkg::RL_DISARM) begin
        tx_bit_d = EXIT_CODE[3'h7 - send_q[2:0]];
      end else if (pat_on) begin
        tx_bit_d = gen_bit;
      end else begin
        tx_bit_d = pin_s2_q[3];
      end
      if (rl_q == line_test_pkg::RL_ARM || rl_q == line_test_pkg::RL_DISARM) begin
        send_d = send_q + 8'h01;
      end
    end
    // Remote loop command sequence
    unique case (rl_q)
      line_test_pkg::RL_IDLE: begin
        send_d = 8'h00;
        if (pin_s2_q[5] && !net_loop) rl_d = line_test_pkg::RL_ARM;
      end
      line_test_pkg::RL_ARM: begin
        if (send_q == 8'(SEND_BITS - 1) && tx_en) rl_d = line_test_pkg::RL_ON;
      end
      line_test_pkg::RL_ON: begin
        send_d = 8'h00;
        if (!pin_s2_q[5]) rl_d = line_test_pkg::RL_DISARM;
      end
      line_test_pkg::RL_DISARM: begin
        if (send_q == 8'(SEND_BITS - 1) && tx_en) rl_d = line_test_pkg::RL_IDLE;
      end
    endcase
    tm_d = analog || net_loop || (rl_q != line_test_pkg::RL_IDLE);
  end

  // Datapath registers
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      div_q <= 12'h000;
      tx_bit_q <= 1'b1;
      tx_clk_q <= 1'b0;
      tx_en_q <= 1'b0;
      rx_last_q <= 1'b1;
      win_q <= 8'h00;
      run_q <= 8'h00;
      cmd_loop_q <= 1'b0;
      rl_q <= line_test_pkg::RL_IDLE;
      send_q <= 8'h00;
      tm_q <= 1'b0;
      err_q <= 1'b0;
      net_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tx_bit_q <= tx_bit_d;
      tx_clk_q <= tx_clk_d;
      tx_en_q <= tx_en;
      rx_last_q <= rx_last_d;
      win_q <= win_d;
      run_q <= run_d;
      cmd_loop_q <= cmd_loop_d;
      rl_q <= rl_d;
      send_q <= send_d;
      tm_q <= tm_d;
      err_q <= chk_err;
      net_q <= net_loop;
    end
  end

  // Register file: one-cycle ack, unmapped reads zero
  assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  // Write lands at the edge where the master sees ack, not when first taken
  assign wr = WB_CYC_IN && WB_STB_IN && WB_ACK_OUT && WB_WE_IN && WB_SEL_IN[0];
  assign ev = {net_q && !net_loop, !net_q && net_loop, chk_err};
  always_comb begin
    ack_d = req;
    ctrl_d = (wr && WB_ADR_IN == `LT_REG_CTRL) ? WB_DAT_IN[3:0] : ctrl_q;
    mask_d = (wr && WB_ADR_IN == `LT_REG_IRQ_MASK) ? WB_DAT_IN[2:0] : mask_q;
    // A new event wins over a write-one clear in the same cycle
    stat_d = stat_q;
    if (wr && WB_ADR_IN == `LT_REG_IRQ_STAT) stat_d = stat_q & ~WB_DAT_IN[2:0];
    stat_d = stat_d | ev;
    errcnt_d = (wr && WB_ADR_IN == `LT_REG_ERR_COUNT) ? 16'h0000 : errcnt_q;
    if (chk_err && errcnt_d != 16'hFFFF) errcnt_d = errcnt_d + 16'h0001;
    irq_d = |(stat_q & mask_q);
    rdat_d = 32'h0000_0000;
    if (req && !WB_WE_IN) begin
      unique case (WB_ADR_IN)
        `LT_REG_CTRL: rdat_d = {28'h0, ctrl_q};
        `LT_REG_STATUS: rdat_d = {24'h0, src, tm_q, chk_sync, cmd_loop_q, pin_s2_q[6],
                                  rl_q == line_test_pkg::RL_ON, analog};
        `LT_REG_IRQ_STAT: rdat_d = {29'h0, stat_q};
        `LT_REG_IRQ_MASK: rdat_d = {29'h0, mask_q};
        `LT_REG_ERR_COUNT: rdat_d = {16'h0, errcnt_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
      ctrl_q <= `LT_CTRL_RESET;
      mask_q <= `LT_IRQ_RESET;
      stat_q <= `LT_IRQ_RESET;
      errcnt_q <= 16'h0000;
      IRQ_OUT <= 1'b0;
    end else begin
      WB_ACK_OUT <= ack_d;
      WB_DAT_OUT <= rdat_d;
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      errcnt_q <= errcnt_d;
      IRQ_OUT <= irq_d;
    end
  end

  assign LINE_TX_DATA_OUT = tx_bit_q;
  assign UNIT_SUPPLIED_TX_CLOCK_OUT = tx_clk_q;
  assign TERM_RX_DATA_OUT = rx_last_q;
  assign TEST_MODE_INDICATOR_OUT = tm_q;
  assign ERROR_PULSE_OUT = err_q;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);

  a_tm_during_loop: assert property ((analog || net_loop) |=> TEST_MODE_INDICATOR_OUT)
    else $error("test mode not shown during loop");
  a_net_loop_echo: assert property ((tx_en && net_loop) |=> LINE_TX_DATA_OUT == $past(rx_last_q))
    else $error("network loop does not return received bit");
  a_cmd_loop_enter: assert property ((rx_en && !analog && !cmd_loop_q &&
                                      code_seen(win_q, run_q, LOOP_CODE)) |=> cmd_loop_q)
    else $error("loop command not honoured");
  a_clk_analog_int: assert property (analog |-> src == line_test_pkg::SRC_INT)
    else $error("analog loop not on internal timing");
  a_clk_int_remote: assert property ((ctrl_q[1:0] == line_test_pkg::CLK_MODE_INT && !analog &&
                                      net_loop) |-> src == line_test_pkg::SRC_RC)
    else $error("answering loop not on receive clock");
  a_pattern_sent: assert property ((tx_en && pat_on && !net_loop && (rl_q == line_test_pkg::RL_IDLE ||
                                    rl_q == line_test_pkg::RL_ON)) |=> LINE_TX_DATA_OUT == $past(gen_bit))
    else $error("pattern bit not sent");
  a_remote_code_sent: assert property ((tx_en && !net_loop && rl_q == line_test_pkg::RL_ARM) |=>
                                       LINE_TX_DATA_OUT == $past(LOOP_CODE[3'h7 - send_q[2:0]]))
    else $error("remote loop command bit wrong");
  a_err_pulse_flag: assert property (chk_err |=> ERROR_PULSE_OUT && stat_q[`LT_IRQ_ERR])
    else $error("mismatch not reported");
  a_local_loop_rx: assert property ((analog && tx_en_q) |=> TERM_RX_DATA_OUT == $past(tx_bit_q))
    else $error("local loop not returned to receiver");

  c_pattern_in_loop: cover property (analog && pat_on && chk_sync);
  c_cmd_loop: cover property (!cmd_loop_q ##1 cmd_loop_q);
  c_remote_on: cover property (rl_q == line_test_pkg::RL_ON);
  c_error_seen: cover property (ERROR_PULSE_OUT && ctrl_q[3:2] == line_test_pkg::PAT_511E);
endmodule
`default_nettype wire

// ==== rtl/line_test_defines.svh ====
// Offsets, field positions, reset values and timing counts of the test block
`ifndef LINE_TEST_DEFINES_SVH
`define LINE_TEST_DEFINES_SVH
`define LT_REG_CTRL 8'h00
`define LT_REG_STATUS 8'h04
`define LT_REG_IRQ_STAT 8'h08
`define LT_REG_IRQ_MASK 8'h0C
`define LT_REG_ERR_COUNT 8'h10
`define LT_CTRL_CLK_LSB 0
`define LT_CTRL_PAT_LSB 2
`define LT_CTRL_RESET 4'h0
`define LT_IRQ_ERR 0
`define LT_IRQ_LOOP_ON 1
`define LT_IRQ_LOOP_OFF 2
`define LT_IRQ_RESET 3'h0
`define LT_PRBS_SEED 9'h1FF
`define LT_PRBS_INTERVAL 511
`define LT_CLK_PERIOD_NS 10
`define LT_INT_BIT_NS 17857
`define LT_CMD_SEND_BITS 128
`define LT_CMD_DETECT_BITS 64
`define LT_LOOP_CODE 8'hA5
`define LT_EXIT_CODE 8'h3C
`endif

// ==== rtl/line_test_pkg.sv ====
// Types shared by the test and loop control block
package line_test_pkg;
  typedef enum logic [1:0] {CLK_MODE_INT, CLK_MODE_EXT, CLK_MODE_NET, CLK_MODE_SPARE} clk_mode_t;
  typedef enum logic [1:0] {PAT_OFF, PAT_511, PAT_511E, PAT_SPARE} pat_mode_t;
  typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_RC} clk_src_t;
  typedef enum logic [1:0] {RL_IDLE, RL_ARM, RL_ON, RL_DISARM} rl_state_t;
endpackage

// ==== rtl/prbs9_gen.sv ====
// Nine-stage pseudorandom generator with periodic error injection
`timescale 1ns/10ps
`default_nettype none
`include "line_test_defines.svh"
module prbs9_gen #(
  parameter int INTERVAL = `LT_PRBS_INTERVAL
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic step_in,    // Advance one bit
  input wire logic inject_in,  // Error-injecting variant on
  output logic bit_out         // Bit to send now
);
  logic [8:0] lfsr_q, lfsr_d;  // Shift state
  logic [9:0] gap_q, gap_d;    // Bits since last injected error
  logic fb;                    // Feedback, taps 9 and 5

  // Next state of shifter and interval counter
  always_comb begin
    fb = lfsr_q[8] ^ lfsr_q[4];
    lfsr_d = lfsr_q;
    gap_d = gap_q;
    if (step_in) begin
      lfsr_d = {lfsr_q[7:0], fb};
      // Counter runs always so the injection period is fixed
      gap_d = (gap_q == 10'(INTERVAL - 1)) ? 10'h000 : gap_q + 10'h001;
    end
    // One inverted bit per interval keeps the far end erroring steadily
    bit_out = fb ^ (inject_in && gap_q == 10'(INTERVAL - 1));
  end

  // Registers only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lfsr_q <= `LT_PRBS_SEED;
      gap_q <= 10'h000;
    end else begin
      lfsr_q <= lfsr_d;
      gap_q <= gap_d;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/prbs9_chk.sv ====
// Self-synchronising checker for the nine-stage pseudorandom sequence
`timescale 1ns/10ps
`default_nettype none
`include "line_test_defines.svh"
module prbs9_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic step_in,  // A received bit is valid
  input wire logic bit_in,   // Received bit
  input wire logic clear_in, // Restart synchronisation
  output logic err_out,      // One-cycle pulse per mismatch
  output logic synced_out    // Nine bits loaded, counting errors
);
  logic [8:0] hist_q, hist_d; // Last nine received bits
  logic [3:0] fill_q, fill_d; // Bits loaded since restart
  logic err_d;

  // Received bits feed the predictor, so it locks after nine bits
  always_comb begin
    hist_d = hist_q;
    fill_d = clear_in ? 4'h0 : fill_q;
    err_d = 1'b0;
    if (step_in && !clear_in) begin
      hist_d = {hist_q[7:0], bit_in};
      if (fill_q == 4'h9) begin
        err_d = bit_in ^ hist_q[8] ^ hist_q[4];
      end else begin
        fill_d = fill_q + 4'h1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hist_q <= 9'h000;
      fill_q <= 4'h0;
      err_out <= 1'b0;
    end else begin
      hist_q <= hist_d;
      fill_q <= fill_d;
      err_out <= err_d;
    end
  end
  assign synced_out = (fill_q == 4'h9);
endmodule
`default_nettype wire

// ==== verif/far_end_unit.sv ====
// Far-end line unit model: recovered clock, idle marks, repeated codes, pattern
`timescale 1ns/10ps
`default_nettype none
module far_end_unit (
  input wire logic clk_in,
  input wire logic [1:0] mode_in, // 0 idle marks, 2 repeated code, 3 pattern
  input wire logic [7:0] code_in, // Code to repeat, sent MSB first
  output logic rclk_out,          // Recovered clock, runs free like a real line
  output logic rx_out             // Line data towards the block
);
  logic [2:0] div_q = 3'h0;    // Clock phase, 8 system cycles a bit
  logic [2:0] idx_q = 3'h7;    // Code bit index
  logic [8:0] lfsr_q = 9'h1FF; // Pattern shifter
  logic bit_q = 1'b1;          // Bit now on the line
  assign rclk_out = div_q[2];
  assign rx_out = bit_q;
  // New bit at the falling clock edge, so it is steady around the rising one
  always @(posedge clk_in) begin
    div_q <= div_q + 3'h1;
    if (div_q == 3'h7) begin
      case (mode_in)
        2'h2: begin
          bit_q <= code_in[idx_q];
          idx_q <= idx_q - 3'h1;
        end
        2'h3: begin
          bit_q <= lfsr_q[8];
          lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
        end
        default: bit_q <= 1'b1; // Idle line marks
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verif/line_test_loop_control_test.sv ====
// Self-checking bench of the test and loop control block
`timescale 1ns/10ps
`default_nettype none
module line_test_loop_control_test;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk, rst, cyc, stb, we, ack, tdata, lloop, rloop, seal;
  logic xclk = 1'b0; // External clock, one driver only
  logic rclk, rxd, txd, tclk, rxo, tm, errp, irq;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, v;
  logic [1:0] fmode; // Far end mode
  logic [7:0] fcode; // Far end code
  logic [15:0] rnd = 16'h0053; // Random source state
  logic [1:0] xdiv = 2'h0;     // External clock divider
  int err_seen = 0;            // Error pulses seen
  int n_errors, checks, e0, e1, e2;
  logic rx_q[$];                   // Receiver output at each transmit bit
  logic [31:0] exp_q[$], msk_q[$]; // Expected read data and its mask
  logic bits_q[$];                 // Captured transmit bits

  // Short counts keep the run brief
  line_test_loop_control #(.INT_DIV(8), .SEND_BITS(16), .DETECT_BITS(16))
      line_test_loop_control_i (
    .CLK_SYS_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .LINE_RX_DATA_IN(rxd),
    .RECOVERED_RECEIVE_CLOCK_IN(rclk), .TERMINAL_SUPPLIED_TX_CLOCK_IN(xclk),
    .TERM_TX_DATA_IN(tdata), .LOCAL_LOOP_REQUEST_IN(lloop),
    .REMOTE_LOOP_REQUEST_IN(rloop), .SEALING_REVERSED_IN(seal),
    .LINE_TX_DATA_OUT(txd), .UNIT_SUPPLIED_TX_CLOCK_OUT(tclk),
    .TERM_RX_DATA_OUT(rxo), .TEST_MODE_INDICATOR_OUT(tm),
    .ERROR_PULSE_OUT(errp), .IRQ_OUT(irq));

  far_end_unit far_end_unit_i (.clk_in(clk), .mode_in(fmode), .code_in(fcode),
    .rclk_out(rclk), .rx_out(rxd));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Random user data and a free external clock at a sixth of the system rate
  always @(posedge clk) begin
    rnd <= lfsr_next(rnd);
    tdata <= rnd[0];
    xdiv <= (xdiv == 2'h2) ? 2'h0 : xdiv + 2'h1;
    if (xdiv == 2'h2) xclk <= ~xclk;
  end

  // Error pulses counted by non-blocking update, so readers see settled values
  always @(posedge clk) if (errp === 1'b1) err_seen <= err_seen + 1;

  // Read monitor: the oldest note is taken off when an answer appears
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      chk(rdat & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic bus cycle; a read notes its expected data first
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    if (!w) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    @(posedge clk);
    while (ack !== 1'b1 && t < 50) begin
      @(posedge clk);
      t++;
    end
    if (t >= 50) chk(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Bounded wait for the test indication to reach a level
  task automatic wait_tm(input logic l, input int lim);
    int t;
    t = 0;
    while (tm !== l && t < lim) begin
      @(posedge clk);
      t++;
    end
    chk(tm, l);
  endtask

  // Transmit bit is taken in the cycle of its clock pulse, with the receiver output
  task automatic get_bits(input int n);
    bits_q.delete();
    rx_q.delete();
    while (bits_q.size() < n) begin
      @(posedge clk);
      if (tclk === 1'b1) begin
        bits_q.push_back(txd);
        rx_q.push_back(rxo);
      end
    end
  endtask

  task automatic find_code(input logic [7:0] c);
    logic [7:0] w;
    logic hit;
    w = 8'h00;
    hit = 1'b0;
    foreach (bits_q[i]) begin
      w = {w[6:0], bits_q[i]};
      if (i >= 7 && w === c) hit = 1'b1;
    end
    chk(hit, 1'b1);
  endtask

  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 11500 cycles
  initial begin
    #500000;
    n_errors++;
    finish_test();
  end

  initial begin
    {rst, cyc, stb, we, lloop, rloop, seal} = 7'h40;
    {adr, wdat, fcode, fmode} = 50'h0;
    n_errors = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    // Only the two data outputs idle high in reset
    chk({txd, rxo, tm, irq, ack, tclk, errp}, 32'h60);
    chk(rdat, 32'h0);
    rst <= 1'b0;
    // Registers: reset values, random write, unmapped and read-only places
    wb(1'b0, 8'h00, 32'h0, ALL);
    wb(1'b0, 8'h0C, 32'h0, ALL);
    v = {rnd, rnd};
    wb(1'b1, 8'h00, v, 32'h0);
    wb(1'b0, 8'h00, v & 32'hF, ALL);
    wb(1'b0, 8'h20, 32'h0, ALL);
    wb(1'b1, 8'h04, ALL, 32'h0);
    wb(1'b0, 8'h04, 32'h0, 32'h3F);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, 8'h00, 32'(m), 32'h0);
      wb(1'b0, 8'h04, 32'(m % 3) << 6, 32'hC0);
    end
    lloop <= 1'b1;
    wait_tm(1'b1, 10);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, 8'h00, 32'(m), 32'h0);
      wb(1'b0, 8'h04, 32'h1, 32'hC1);
    end
    // Pattern in local loop checks its own sequence
    wb(1'b1, 8'h00, 32'h4, 32'h0);
    get_bits(20);
    wb(1'b1, 8'h10, 32'h0, 32'h0);
    get_bits(60);
    for (int i = 9; i < 60; i++) chk(bits_q[i], bits_q[i-9] ^ bits_q[i-5]);
    // Own transmit bit shows at the receiver output one bit later
    for (int i = 1; i < 60; i++) chk(rx_q[i], bits_q[i-1]);
    wb(1'b0, 8'h10, 32'h0, ALL);
    wb(1'b0, 8'h04, 32'h31, 32'h31);
    // Error-injecting variant: equal nonzero counts in aligned windows
    wb(1'b1, 8'h00, 32'h8, 32'h0);
    get_bits(20);
    e0 = err_seen;
    get_bits(511);
    e1 = err_seen - e0;
    get_bits(511);
    e2 = err_seen - e0 - e1;
    chk(32'(e1 == 0), 32'h0);
    chk(e2, e1);
    chk(irq, 1'b0);
    wb(1'b1, 8'h0C, 32'h1, 32'h0);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wb(1'b1, 8'h00, 32'h0, 32'h0);
    lloop <= 1'b0;
    wb(1'b1, 8'h08, 32'h1, 32'h0);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    wb(1'b0, 8'h08, 32'h0, 32'h1);
    wb(1'b1, 8'h0C, 32'h0, 32'h0);
    // Both ends run the pattern on network timing
    fmode <= 2'h3;
    wb(1'b1, 8'h00, 32'h6, 32'h0);
    get_bits(30);
    e0 = err_seen;
    get_bits(100);
    chk(err_seen - e0, 32'h0);
    wb(1'b0, 8'h04, 32'h10, 32'h10);
    wb(1'b1, 8'h00, 32'h0, 32'h0);
    // Sealing current reversal echoes the line
    fcode <= 8'h00;
    fmode <= 2'h2;
    seal <= 1'b1;
    wait_tm(1'b1, 10);
    get_bits(20);
    for (int i = 10; i < 20; i++) chk(bits_q[i], 1'b0);
    wb(1'b0, 8'h04, 32'h24, 32'h24);
    seal <= 1'b0;
    wait_tm(1'b0, 10);
    // Clear the sealing loop events so the command loop must set them again
    wb(1'b1, 8'h08, 32'h7, 32'h0);
    // Network loop command, clock source while answering, then exit code
    fcode <= 8'hA5;
    wait_tm(1'b1, 3000);
    wb(1'b0, 8'h08, 32'h2, 32'h2);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, 8'h00, 32'(m), 32'h0);
      wb(1'b0, 8'h04, ((m == 1) ? 32'h48 : 32'h88), 32'hC8);
    end
    get_bits(24);
    find_code(8'hA5);
    fcode <= 8'h3C;
    wait_tm(1'b0, 3000);
    wb(1'b0, 8'h08, 32'h4, 32'h4);
    fmode <= 2'h0;
    wb(1'b1, 8'h08, 32'h7, 32'h0);
    // Remote loop request on internal timing
    wb(1'b1, 8'h00, 32'h0, 32'h0);
    rloop <= 1'b1;
    wait_tm(1'b1, 20);
    get_bits(16);
    find_code(8'hA5);
    get_bits(16);
    wb(1'b0, 8'h04, 32'h22, 32'hE2);
    rloop <= 1'b0;
    get_bits(16);
    find_code(8'h3C);
    wait_tm(1'b0, 400);
    finish_test();
  end
endmodule
`default_nettype wire
